// ===== hdl/setq_pkg.sv
package setq_pkg;

    // ****************************************************************
    // port set and register map
    // ****************************************************************
    localparam int              NUM_PORTS = 5;
    localparam logic [4:0][7:0] EGRESS_TAG_ADDR  = {8'hf0, 8'he0, 8'hd0, 8'hc0, 8'hb0};
    localparam logic [4:0][7:0] QUEUE_SPLIT_ADDR = {8'hf1, 8'he1, 8'hd1, 8'hc1, 8'hb1};

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PASS_ALL_BIT = 6;
    localparam int SPLIT4_BIT   = 1;
    localparam int DROP_TAG_BIT = 0;
    localparam int INS_SEL_MSB  = 3;

    // ****************************************************************
    // values after reset, writable masks and read data for unmapped addresses
    // ****************************************************************
    localparam logic [7:0] EGRESS_TAG_RST    = 8'h80;
    localparam logic [7:0] EGRESS_TAG_WMASK  = 8'h4f;
    localparam logic [7:0] QUEUE_SPLIT_RST   = 8'h00;
    localparam logic [7:0] QUEUE_SPLIT_WMASK = 8'h03;
    localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;

    // ****************************************************************
    // output queue split, coded as {split4 bit, queue bit 0}
    // ****************************************************************
    typedef enum logic [1:0] {
        SETQ_Q_SINGLE = 2'b00,
        SETQ_Q_TWO    = 2'b01,
        SETQ_Q_FOUR   = 2'b10,
        SETQ_Q_RSVD   = 2'b11
    } setq_qmode_t;

    // egress port reached by insertion select bit sel for source port src
    function automatic logic [2:0] setq_ins_target(input logic [2:0] src,
                                                   input logic [1:0] sel);
        logic [2:0] upper;
        upper = {1'b0, sel} + 3'h2;
        return (src < upper) ? upper : upper - 3'h1;
    endfunction

endpackage

// ===== hdl/setq_port_cfg.sv
`timescale 1ns/1ps
module setq_port_cfg (
    // clock, reset and enable
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // register writes
    input  wire logic                 wr_egress_tag,
    input  wire logic                 wr_queue_split,
    input  wire logic [7:0]           wdata,
    // port context
    input  wire logic                 queue_bit0,
    // configuration
    output logic      [7:0]           egress_tag_ctrl,
    output logic      [7:0]           queue_split_ctrl,
    output logic                      pass_all,
    output logic                      tagged_drop,
    output logic      [3:0]           insert_sel,
    output setq_pkg::setq_qmode_t     queue_mode
);

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            egress_tag_ctrl <= setq_pkg::EGRESS_TAG_RST;
        end else if (ce && wr_egress_tag) begin
            egress_tag_ctrl <= (wdata & setq_pkg::EGRESS_TAG_WMASK)
                             | (setq_pkg::EGRESS_TAG_RST & ~setq_pkg::EGRESS_TAG_WMASK);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            queue_split_ctrl <= setq_pkg::QUEUE_SPLIT_RST;
        end else if (ce && wr_queue_split) begin
            queue_split_ctrl <= (wdata & setq_pkg::QUEUE_SPLIT_WMASK)
                              | (setq_pkg::QUEUE_SPLIT_RST & ~setq_pkg::QUEUE_SPLIT_WMASK);
        end
    end

    assign pass_all    = egress_tag_ctrl[setq_pkg::PASS_ALL_BIT];     // RULE1
    assign tagged_drop = queue_split_ctrl[setq_pkg::DROP_TAG_BIT];    // RULE8
    assign insert_sel  = egress_tag_ctrl[setq_pkg::INS_SEL_MSB:0];

    // ****************************************************************
    // output queue split
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            queue_mode <= setq_pkg::SETQ_Q_SINGLE;
        end else if (ce) begin
            case ({queue_split_ctrl[setq_pkg::SPLIT4_BIT], queue_bit0}) // RULE7
                2'b10: begin
                    queue_mode <= setq_pkg::SETQ_Q_FOUR;
                end
                2'b01: begin
                    queue_mode <= setq_pkg::SETQ_Q_TWO;
                end
                2'b00: begin
                    queue_mode <= setq_pkg::SETQ_Q_SINGLE;
                end
                default: begin
                    queue_mode <= setq_pkg::SETQ_Q_RSVD;
                end
            endcase
        end
    end

endmodule

// ===== hdl/setq_egress_tag_ctrl.sv
// Summary of operation
// RULE1: pass-every-frame bit lets all frames received on the port pass; resets to zero.
// RULE2: bit 3 inserts source default VLAN ID at highest other egress port.
// RULE3: bit 2 inserts source default VLAN ID at second-highest other egress port.
// RULE4: bit 1 inserts source default VLAN ID at second-lowest other egress port.
// RULE5: bit 0 inserts source default VLAN ID at lowest other egress port.
// RULE6: insertion selections act only while the global insertion enable is set.
// RULE7: split4 bit with queue bit 0: 10 four, 01 two, 00 one queue.
// RULE8: tagged-drop bit drops VLAN-tagged packets on the port; resets to zero.
// RULE9: frames already tagged are never given an inserted tag.
`timescale 1ns/1ps
module setq_egress_tag_ctrl (
    // clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // register port
    input  wire logic      [7:0]      reg_addr,
    input  wire logic      [7:0]      reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic           [7:0]      reg_rdata,
    output logic                      reg_ack,
    // switch context
    input  wire logic                 glob_insert_en,
    input  wire logic      [4:0]      queue_bit0,
    // per-port configuration
    output logic           [4:0]      pass_all,
    output logic           [4:0]      tagged_drop,
    output logic           [4:0][1:0] queue_mode,
    // frame decision request
    input  wire logic                 frm_valid,
    input  wire logic      [2:0]      frm_src,
    input  wire logic      [2:0]      frm_dst,
    input  wire logic                 frm_tagged,
    // frame decision answer
    output logic                      dec_valid,
    output logic                      dec_insert_vid,
    output logic                      dec_drop,
    output logic                      dec_pass_all
);

    logic [4:0]      wr_egress_tag;
    logic [4:0]      wr_queue_split;
    logic [4:0][7:0] egress_tag_ctrl;
    logic [4:0][7:0] queue_split_ctrl;
    logic [4:0][3:0] insert_sel;
    logic [7:0]      next_rdata;
    logic            src_ok;
    logic [2:0]      src_idx;
    logic            ins_hit;

    // ****************************************************************
    // address decode
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < setq_pkg::NUM_PORTS; i++) begin
            wr_egress_tag[i]  = reg_wr && (reg_addr == setq_pkg::EGRESS_TAG_ADDR[i]);
            wr_queue_split[i] = reg_wr && (reg_addr == setq_pkg::QUEUE_SPLIT_ADDR[i]);
        end
    end

    always_comb begin
        next_rdata = setq_pkg::UNMAPPED_RDATA;
        for (int i = 0; i < setq_pkg::NUM_PORTS; i++) begin
            if (reg_addr == setq_pkg::EGRESS_TAG_ADDR[i]) begin
                next_rdata = egress_tag_ctrl[i];
            end
            if (reg_addr == setq_pkg::QUEUE_SPLIT_ADDR[i]) begin
                next_rdata = queue_split_ctrl[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_ack <= 1'b0;
        end else if (ce) begin
            reg_ack <= reg_rd || reg_wr;
        end
    end

    // ****************************************************************
    // per-port registers
    // ****************************************************************
    for (genvar p = 0; p < setq_pkg::NUM_PORTS; p++) begin : g_port
        setq_port_cfg u_cfg (
            .ref_clk          (ref_clk),
            .resetn           (resetn),
            .ce               (ce),
            .wr_egress_tag    (wr_egress_tag[p]),
            .wr_queue_split   (wr_queue_split[p]),
            .wdata            (reg_wdata),
            .queue_bit0       (queue_bit0[p]),
            .egress_tag_ctrl  (egress_tag_ctrl[p]),
            .queue_split_ctrl (queue_split_ctrl[p]),
            .pass_all         (pass_all[p]),
            .tagged_drop      (tagged_drop[p]),
            .insert_sel       (insert_sel[p]),
            .queue_mode       (queue_mode[p])
        );
    end

    // ****************************************************************
    // frame decision
    // ****************************************************************
    assign src_ok  = (frm_src >= 3'h1) && (frm_src <= 3'h5);
    assign src_idx = src_ok ? frm_src - 3'h1 : 3'h0;

    // each select bit maps the source to one egress port
    always_comb begin
        ins_hit = 1'b0;
        if (src_ok && glob_insert_en && !frm_tagged) begin // RULE6 RULE9
            for (int b = 0; b <= setq_pkg::INS_SEL_MSB; b++) begin
                if (insert_sel[src_idx][b]
                    && (setq_pkg::setq_ins_target(frm_src, 2'(b)) == frm_dst)) begin
                    ins_hit = 1'b1; // RULE2 RULE3 RULE4 RULE5
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dec_valid <= 1'b0;
        end else if (ce) begin
            dec_valid <= frm_valid;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dec_insert_vid <= 1'b0;
            dec_drop       <= 1'b0;
            dec_pass_all   <= 1'b0;
        end else if (ce && frm_valid) begin
            dec_insert_vid <= ins_hit;
            dec_drop       <= src_ok && frm_tagged && tagged_drop[src_idx]; // RULE8
            dec_pass_all   <= src_ok && pass_all[src_idx];                  // RULE1
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_pass_all_frame: assert property ( // RULE1
        ce && frm_valid && frm_src == 3'h2 && pass_all[1] |=> dec_valid && dec_pass_all)
        else $error("pass-all not reported for port 2 frame");

    a_highest_target: assert property ( // RULE2
        ce && frm_valid && !frm_tagged && glob_insert_en && frm_src == 3'h5
        && frm_dst == 3'h4 && egress_tag_ctrl[4][3] |=> dec_insert_vid)
        else $error("port 5 to port 4 insertion missing");

    a_second_high: assert property ( // RULE3
        ce && frm_valid && !frm_tagged && glob_insert_en && frm_src == 3'h1
        && frm_dst == 3'h4 && egress_tag_ctrl[0][2] |=> dec_insert_vid)
        else $error("port 1 to port 4 insertion missing");

    a_second_low: assert property ( // RULE4
        ce && frm_valid && !frm_tagged && glob_insert_en && frm_src == 3'h3
        && frm_dst == 3'h2 && egress_tag_ctrl[2][1] |=> dec_insert_vid)
        else $error("port 3 to port 2 insertion missing");

    a_lowest_target: assert property ( // RULE5
        ce && frm_valid && !frm_tagged && glob_insert_en && frm_src == 3'h2
        && frm_dst == 3'h1 && egress_tag_ctrl[1][0] |=> dec_insert_vid)
        else $error("port 2 to port 1 insertion missing");

    a_insert_gated: assert property ( // RULE6
        ce && frm_valid && !glob_insert_en |=> !dec_insert_vid)
        else $error("insertion while globally disabled");

    a_queue_four: assert property ( // RULE7
        ce && queue_split_ctrl[0][1] && !queue_bit0[0]
        |=> queue_mode[0] == setq_pkg::SETQ_Q_FOUR)
        else $error("four-queue split not applied");

    a_queue_two: assert property ( // RULE7
        ce && !queue_split_ctrl[3][1] && queue_bit0[3]
        |=> queue_mode[3] == setq_pkg::SETQ_Q_TWO)
        else $error("two-queue split not applied");

    a_drop_tagged: assert property ( // RULE8
        ce && frm_valid && src_ok |=> dec_drop == ($past(frm_tagged)
        && $past(tagged_drop) != 5'h00 && $past(tagged_drop[src_idx])))
        else $error("tagged drop decision wrong");

    a_tagged_kept: assert property ( // RULE9
        ce && frm_valid && frm_tagged |=> !dec_insert_vid)
        else $error("tag inserted into tagged frame");

    a_write_reads: assert property (
        ce && reg_wr && reg_addr == setq_pkg::QUEUE_SPLIT_ADDR[0]
        ##1 ce && reg_rd && reg_addr == setq_pkg::QUEUE_SPLIT_ADDR[0]
        |=> reg_ack && reg_rdata == ($past(reg_wdata, 2) & setq_pkg::QUEUE_SPLIT_WMASK))
        else $error("written split register reads back wrong");

    c_four_queue: cover property (queue_mode[4] == setq_pkg::SETQ_Q_FOUR);
    c_insert_made: cover property (dec_valid && dec_insert_vid);
    c_tag_dropped: cover property (dec_valid && dec_drop);
    c_read_back: cover property (reg_ack && reg_rdata == 8'hc0);

endmodule

// ===== bench/switch_port_egress_tag_queue_ctrl_test.sv
`timescale 1ns/1ps
module switch_port_egress_tag_queue_ctrl_test;
    // ****************************************
    // stimulus, answers and model state
    // ****************************************
    logic            ref_clk        = 1'b0;
    logic            resetn         = 1'b0;
    logic            ce             = 1'b1;
    logic [7:0]      reg_addr       = 8'h00;
    logic [7:0]      reg_wdata      = 8'h00;
    logic            reg_wr         = 1'b0;
    logic            reg_rd         = 1'b0;
    logic            glob_insert_en = 1'b0;
    logic [4:0]      queue_bit0     = 5'h00;
    logic            frm_valid      = 1'b0;
    logic [2:0]      frm_src        = 3'h1;
    logic [2:0]      frm_dst        = 3'h1;
    logic            frm_tagged     = 1'b0;
    logic [7:0]      reg_rdata;
    logic            reg_ack;
    logic [4:0]      pass_all;
    logic [4:0]      tagged_drop;
    logic [4:0][1:0] queue_mode;
    logic            dec_valid;
    logic            dec_insert_vid;
    logic            dec_drop;
    logic            dec_pass_all;
    logic [7:0]      egr [5];
    logic [7:0]      spl [5];
    int              miscompares    = 0;
    int              check_count    = 0;

    always #5 ref_clk = ~ref_clk;

    setq_egress_tag_ctrl u_setq_egress_tag_ctrl (
        .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .glob_insert_en(glob_insert_en), .queue_bit0(queue_bit0),
        .pass_all(pass_all), .tagged_drop(tagged_drop), .queue_mode(queue_mode),
        .frm_valid(frm_valid), .frm_src(frm_src), .frm_dst(frm_dst),
        .frm_tagged(frm_tagged), .dec_valid(dec_valid), .dec_insert_vid(dec_insert_vid),
        .dec_drop(dec_drop), .dec_pass_all(dec_pass_all)
    );

    // ****************************************
    // checking and access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic model_reset();
        for (int p = 0; p < 5; p++) begin
            egr[p] = 8'h80;
            spl[p] = 8'h00;
        end
    endtask

    // one access: strobe for a cycle, answer seen the cycle after
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] exp;
        exp = 8'h00;
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk("reg_ack", {7'h00, reg_ack}, 8'h01);
        for (int p = 0; p < 5; p++) begin
            if (a == setq_pkg::EGRESS_TAG_ADDR[p]) begin
                if (wr) egr[p] = (d & 8'h4f) | 8'h80;
                exp = egr[p];
            end
            if (a == setq_pkg::QUEUE_SPLIT_ADDR[p]) begin
                if (wr) spl[p] = d & 8'h03;
                exp = spl[p];
            end
        end
        if (!wr) chk("reg_rdata", reg_rdata, exp);
    endtask

    task automatic cfg_chk();
        repeat (2) @(negedge ref_clk);
        for (int p = 0; p < 5; p++) begin
            chk("pass_all", {7'h00, pass_all[p]}, {7'h00, egr[p][6]});
            chk("tagged_drop", {7'h00, tagged_drop[p]}, {7'h00, spl[p][0]});
            chk("queue_mode", {6'h00, queue_mode[p]}, {6'h00, spl[p][1], queue_bit0[p]});
        end
    endtask

    // expected insert: bit b picks the (b+1)-th lowest port other than the source
    task automatic frame(input logic [2:0] s, input logic [2:0] d, input logic t);
        logic ins;
        logic drp;
        logic pas;
        int   idx;
        ins = 1'b0;
        drp = 1'b0;
        pas = 1'b0;
        idx = 0;
        @(negedge ref_clk);
        chk("dec_valid", {7'h00, dec_valid}, 8'h00);
        frm_src = s;
        frm_dst = d;
        frm_tagged = t;
        frm_valid = 1'b1;
        if (s >= 1 && s <= 5) begin
            for (int p = 1; p <= 5; p++) begin
                if (p != s) begin
                    if (egr[s-1][idx] && p == d) ins = 1'b1;
                    idx++;
                end
            end
            drp = t && spl[s-1][0];
            pas = egr[s-1][6];
        end
        ins = ins && glob_insert_en && !t;
        @(negedge ref_clk);
        frm_valid = 1'b0;
        chk("dec_valid", {7'h00, dec_valid}, 8'h01);
        chk("dec_insert_vid", {7'h00, dec_insert_vid}, {7'h00, ins});
        chk("dec_drop", {7'h00, dec_drop}, {7'h00, drp});
        chk("dec_pass_all", {7'h00, dec_pass_all}, {7'h00, pas});
    endtask

    initial begin
        #200us;
        miscompares++;
        end_sim();
    end

    initial begin
        int         p;
        logic [7:0] a;
        void'($urandom(27799));
        model_reset();
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        for (p = 0; p < 5; p++) begin
            reg_acc(1'b0, setq_pkg::EGRESS_TAG_ADDR[p], 8'h00);
            reg_acc(1'b0, setq_pkg::QUEUE_SPLIT_ADDR[p], 8'h00);
        end
        reg_acc(1'b1, 8'hb2, 8'hff);
        reg_acc(1'b0, 8'hb2, 8'h00);
        cfg_chk();
        for (int n = 0; n < 40; n++) begin
            p = $urandom_range(4, 0);
            a = $urandom_range(1, 0) ? setq_pkg::EGRESS_TAG_ADDR[p] : setq_pkg::QUEUE_SPLIT_ADDR[p];
            reg_acc(1'b1, a, 8'($urandom));
            reg_acc(1'b0, a, 8'h00);
            queue_bit0 = 5'($urandom);
            glob_insert_en = 1'($urandom);
            cfg_chk();
            repeat (8) frame(3'($urandom_range(7, 0)), 3'($urandom_range(5, 1)), 1'($urandom));
        end
        glob_insert_en = 1'b1;
        for (int s = 1; s <= 5; s++) begin
            reg_acc(1'b1, setq_pkg::EGRESS_TAG_ADDR[s-1], 8'h0f);
            for (int d = 1; d <= 5; d++) frame(3'(s), 3'(d), 1'b0);
        end
        @(negedge ref_clk);
        glob_insert_en = 1'b0;
        frame(3'h2, 3'h5, 1'b0);
        // write then read of one register on the very next cycle
        @(negedge ref_clk);
        reg_addr = setq_pkg::QUEUE_SPLIT_ADDR[0];
        reg_wdata = 8'($urandom);
        reg_wr = 1'b1;
        spl[0] = reg_wdata & 8'h03;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        chk("reg_ack", {7'h00, reg_ack}, 8'h01);
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("reg_ack", {7'h00, reg_ack}, 8'h01);
        chk("reg_rdata", reg_rdata, spl[0]);
        // a write offered while the clock enable is low must not land
        @(negedge ref_clk);
        ce = 1'b0;
        reg_addr = 8'hb0;
        reg_wdata = 8'h40;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        ce = 1'b1;
        reg_acc(1'b0, 8'hb0, 8'h00);
        @(negedge ref_clk);
        resetn = 1'b0;
        @(negedge ref_clk);
        resetn = 1'b1;
        model_reset();
        for (p = 0; p < 5; p++) reg_acc(1'b0, setq_pkg::EGRESS_TAG_ADDR[p], 8'h00);
        cfg_chk();
        end_sim();
    end
endmodule
